// file: marl_pkg.sv
/*
  Shared constants and carrier types for the monitor alert and reset logic:
  timing counts, bus address, register offsets, field positions, reset
  values, the event struct from the bus link to the core and the temperature struct.
  Assumes a 20 MHz monitor clock.
*/
package marl_pkg;

  // timing
  localparam int CLOCK_HZ          = 20_000_000;
  localparam int RESET_HOLD_MS     = 140; // least reset hold period
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_MS * (CLOCK_HZ / 1000);
  localparam int START_HOLD_NS     = 400; // link clear pulse after a start
  localparam int START_HOLD_CYCLES =
    (START_HOLD_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] START_HOLD   = 4'(START_HOLD_CYCLES);
  localparam logic [1:0] STRAP_SETTLE = 2'h2; // cycles before strap capture

  // bus address and bit positions within a nine-clock byte slot
  localparam logic [4:0] BUS_ADDR_HIGH  = 5'h0b;
  localparam logic [3:0] LINK_ACK_EDGE  = 4'h8;
  localparam logic [3:0] LINK_LAST_EDGE = 4'h9;
  // cleared count wraps to 0 on the start fall, so the r/w fall is edge 8
  localparam logic [3:0] LINK_CNT_CLEAR = 4'hf;

  // register offsets
  localparam logic [7:0] REG_TEMP_REMOTE2  = 8'h25;
  localparam logic [7:0] REG_TEMP_REMOTE1  = 8'h26;
  localparam logic [7:0] REG_TEMP_INTERNAL = 8'h27;
  localparam logic [7:0] REG_LIMIT_REMOTE1 = 8'h37;
  localparam logic [7:0] REG_LIMIT_REMOTE2 = 8'h38;
  localparam logic [7:0] REG_LIMIT_INT     = 8'h39;
  localparam logic [7:0] REG_ANALOG_OUT    = 8'h19;
  localparam logic [7:0] REG_CONFIG        = 8'h40;
  localparam logic [7:0] REG_STATUS        = 8'h41;
  localparam logic [7:0] REG_MASK          = 8'h43;
  localparam logic [7:0] REG_STATUS_MIRROR = 8'h4c;

  // configuration fields
  localparam int CFG_INT_ENABLE   = 1;
  localparam int CFG_FAN_OFF      = 2;
  localparam int CFG_GPI_POLARITY = 3;
  localparam int CFG_DIODE2_MODE  = 7;

  // status fields
  localparam int ST_INTERNAL = 0;
  localparam int ST_REMOTE1  = 1;
  localparam int ST_REMOTE2  = 2;
  localparam int ST_OVERTEMP = 3;
  localparam int ST_GPI      = 4;
  localparam int ST_HW_TRIP  = 5;

  // reset values
  localparam logic [7:0] CONFIG_RESET     = 8'h00;
  localparam logic [7:0] MASK_RESET       = 8'h00;
  localparam logic [7:0] ANALOG_OUT_RESET = 8'hff;
  localparam logic [7:0] LIMIT_RESET      = 8'h7f;
  localparam logic [7:0] HW_TRIP_DEFAULT  = 8'h50;
  localparam logic [7:0] FAN_FULL         = 8'hff;

  // events from the bus link into the core
  typedef struct packed {
    logic       wr_tog;
    logic       rd_tog;
    logic       first;
    logic [7:0] data;
  } marl_link_evt_t;

  // measured temperatures, twos complement
  typedef struct packed {
    logic [7:0] internal;
    logic [7:0] remote1;
    logic [7:0] remote2;
  } marl_temps_t;

endpackage : marl_pkg

// file: marl_link.sv
/*
  Serial bus link: byte shifter, address match, acknowledge and read data
  drive, all on the falling edge of the bus clock.
  Assumes the core holds link_clear high while the bus is idle and pulses
  it after each start; dev_addr and rd_byte are quasi-static.
*/
`timescale 1ns/1ps
module marl_link (
  // link clock and clear
  input  wire logic                 scl,
  input  wire logic                 link_clear,
  // data line
  input  wire logic                 sda_in,
  output logic                      sda_oe,
  // core side
  input  wire logic [6:0]           dev_addr,
  input  wire logic [7:0]           rd_byte,
  output marl_pkg::marl_link_evt_t  evt
);

  typedef struct packed {
    logic [3:0]               cnt;
    logic                     addr_phase;
    logic                     matched;
    logic                     rw;
    logic                     first;
    logic                     reading;
    logic [6:0]               sft;
    logic [7:0]               tx;
    logic                     oe;
    marl_pkg::marl_link_evt_t evt;
  } marl_lk_st_t;

  marl_lk_st_t s;
  marl_lk_st_t next_s;
  logic [7:0]  rx_byte;

  // sampling on the falling edge sees the bit held through the high phase
  always_comb begin
    next_s  = s;
    rx_byte = {s.sft, sda_in};
    next_s.sft = rx_byte[6:0];
    next_s.cnt = (s.cnt == marl_pkg::LINK_LAST_EDGE) ? 4'h1 : s.cnt + 4'h1;
    if (next_s.cnt == marl_pkg::LINK_ACK_EDGE) begin
      next_s.oe = 1'b0;
      if (s.addr_phase) begin
        next_s.addr_phase = 1'b0;
        next_s.matched    = (rx_byte[7:1] == dev_addr);
        next_s.rw         = rx_byte[0];
        next_s.first      = 1'b1;
        next_s.oe         = (rx_byte[7:1] == dev_addr);
      end else if (s.matched && !s.rw) begin
        next_s.evt.data   = rx_byte;
        next_s.evt.first  = s.first;
        next_s.evt.wr_tog = ~s.evt.wr_tog;
        next_s.first      = 1'b0;
        next_s.oe         = 1'b1;
      end
    end else if (next_s.cnt == marl_pkg::LINK_LAST_EDGE) begin
      // master ack (low) asks for another byte, no ack ends the read
      next_s.oe      = 1'b0;
      next_s.reading = 1'b0;
      if (s.matched && s.rw && (!s.reading || !sda_in)) begin
        next_s.reading    = 1'b1;
        next_s.tx         = {rd_byte[6:0], 1'b0};
        next_s.oe         = ~rd_byte[7];
        next_s.evt.rd_tog = ~s.evt.rd_tog;
      end
    end else if (s.reading) begin
      next_s.oe = ~s.tx[7];
      next_s.tx = {s.tx[6:0], 1'b0};
    end
  end

  // toggles also clear here; the core masks events while it clears us
  always_ff @(negedge scl or posedge link_clear) begin
    if (link_clear) begin
      s            <= '0;
      s.cnt        <= marl_pkg::LINK_CNT_CLEAR;
      s.addr_phase <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign sda_oe = s.oe;
  assign evt    = s.evt;

endmodule : marl_link

// file: marl_core.sv
/*
  Monitor alert and reset logic: reset generators, open-drain alert, fan
  and overtemperature pins, status latching, shared-pin modes and the
  register file reached through the serial bus link.
  Assumes pad cells resolve each open-drain pin from its _OE (low when
  high) and that temperatures arrive on the monitor clock.
*/
//
// Contract
// - manual reset low holds system reset low
// - system reset held one period after manual release
// - supply reset low while supply low, plus period
// - external supply-reset low resets device; board isolates it
// - system reset covers all sources, plus one period
// - fan off pin pulled low requests fan off
// - test pin high selects test, else fan output
// - diode2 pins are diode or overtemp plus input
// - digital mode drives overtemp low on violation
// - external overtemp low sets status, fan full
// - general input polarity programmable, sets status bit4
// - input status clears only on inactive read
// - address strap sampled once at power up
// - test mode turns address pin into output
// - alert works only with config bit1 set
// - first written byte goes to register pointer
// - status mirrored at register 4c
// - mask blocks each source from the alert
// - hardware trip forces fan full automatically
// - alert and overtemp outputs flag both limits
// - values and limits registered and compared
// - fan code held in writable output register
// - config bit7 selects second diode, default off
// - bus address is 01011 plus strap bits
`timescale 1ns/1ps
module marl_core #(
  parameter int         RESET_HOLD_CYCLES = marl_pkg::RESET_HOLD_CYCLES,
  parameter logic [7:0] HW_TRIP           = marl_pkg::HW_TRIP_DEFAULT
) (
  // clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  // serial bus link
  input  wire logic                  SCL,
  input  wire logic                  SDA_IN,
  output logic                       SDA_OE,
  // supply comparators
  input  wire logic                  SUPPLY_BELOW,
  input  wire logic                  AUX_VOLTAGE_MONITOR,
  // reset pins
  input  wire logic                  MANUAL_RESET_N,
  input  wire logic                  SUPPLY_RESET_N_IN,
  output logic                       SUPPLY_RESET_N_OE,
  output logic                       SYSTEM_RESET_N_OE,
  // fan control
  output logic                       FAN_OFF_OE,
  input  wire logic                  FAN_SPEED_OUT_OR_TEST_IN,
  output logic                       FAN_SPEED_ENABLE,
  output logic [7:0]                 FAN_SPEED_CODE,
  // second diode pins
  output logic                       DIODE2_ANALOG_MODE,
  input  wire logic                  DIODE2_NEG_OR_OVERTEMP_N_IN,
  output logic                       DIODE2_NEG_OR_OVERTEMP_N_OE,
  input  wire logic                  DIODE2_POS_OR_GENERAL_INPUT,
  // address pin
  input  wire logic [1:0]            ADDRESS_SELECT,
  output logic                       ADDRESS_SELECT_OR_TEST_OUT,
  output logic                       ADDRESS_SELECT_OR_TEST_OUT_OE,
  // alert and measurements
  output logic                       ALERT_OE,
  input  wire marl_pkg::marl_temps_t TEMPS
);

  localparam int HW = $clog2(RESET_HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD = HW'(RESET_HOLD_CYCLES);

  typedef struct packed {
    logic scl1, scl2, scl_q, sda1, sda2, sda_q;
    logic mr1, mr2, sup1, sup2, aux1, aux2, srp1, srp2;
    logic th1, th2, gp1, gp2, tst1, tst2;
    logic [1:0] as1, as2;
    logic wr1, wr2, wr_q, rd1, rd2, rd_q;
    logic lk_idle;
    logic [3:0] start_cnt;
    logic lk_clr;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] addr_lo;
    logic [7:0] ptr, cfg, status, mask, aout;
    logic [7:0] lim_int, lim_r1, lim_r2, rd_byte;
    marl_pkg::marl_temps_t val;
    logic [HW-1:0] sup_cnt, sys_cnt;
    logic sup_oe, sys_oe;
    logic [1:0] sup_hist, th_hist;
    logic therm_oe, alert_oe, test_oe, test_out;
    logic [7:0] fan_code;
  } marl_core_st_t;

  marl_core_st_t            s;
  marl_core_st_t            next_s;
  marl_pkg::marl_link_evt_t evt;
  logic                     link_sda_oe;
  logic                     start, stop, wr_evt, rd_evt, rd_hit;
  logic                     digital, gpi_act, hw_trip, ext_therm, ext_sup;
  logic                     sys_cond;
  logic [7:0]               set, clr;

  // bus link on its own clock; clear is async so a start is never missed
  marl_link u_link (
    .scl        (SCL),
    .link_clear (RST | s.lk_clr),
    .sda_in     (SDA_IN),
    .sda_oe     (link_sda_oe),
    .dev_addr   ({marl_pkg::BUS_ADDR_HIGH, s.addr_lo}),
    .rd_byte    (s.rd_byte),
    .evt        (evt)
  );

  // all monitor-clock behaviour in one next-state function
  always_comb begin
    next_s = s;
    // two-flop synchronisers for pins and link toggles
    next_s.scl1 = SCL;
    next_s.scl2 = s.scl1;
    next_s.scl_q = s.scl2;
    next_s.sda1 = SDA_IN;
    next_s.sda2 = s.sda1;
    next_s.sda_q = s.sda2;
    next_s.mr1 = MANUAL_RESET_N;
    next_s.mr2 = s.mr1;
    next_s.sup1 = SUPPLY_BELOW;
    next_s.sup2 = s.sup1;
    next_s.aux1 = AUX_VOLTAGE_MONITOR;
    next_s.aux2 = s.aux1;
    next_s.srp1 = SUPPLY_RESET_N_IN;
    next_s.srp2 = s.srp1;
    next_s.th1 = DIODE2_NEG_OR_OVERTEMP_N_IN;
    next_s.th2 = s.th1;
    next_s.gp1 = DIODE2_POS_OR_GENERAL_INPUT;
    next_s.gp2 = s.gp1;
    next_s.tst1 = FAN_SPEED_OUT_OR_TEST_IN;
    next_s.tst2 = s.tst1;
    next_s.as1 = ADDRESS_SELECT;
    next_s.as2 = s.as1;
    next_s.wr1 = evt.wr_tog;
    next_s.wr2 = s.wr1;
    next_s.wr_q = s.wr2;
    next_s.rd1 = evt.rd_tog;
    next_s.rd2 = s.rd1;
    next_s.rd_q = s.rd2;

    // start and stop framing; link is held clear while idle
    start = s.scl2 & s.scl_q & s.sda_q & ~s.sda2;
    stop  = s.scl2 & s.scl_q & ~s.sda_q & s.sda2;
    next_s.start_cnt = start ? marl_pkg::START_HOLD :
      ((s.start_cnt != 4'h0) ? s.start_cnt - 4'h1 : 4'h0);
    if (start) begin
      next_s.lk_idle = 1'b0;
    end else if (stop) begin
      next_s.lk_idle = 1'b1;
    end
    next_s.lk_clr = next_s.lk_idle | (next_s.start_cnt != 4'h0);
    // toggles flip back when cleared, so ignore them while clearing
    wr_evt = (s.wr2 ^ s.wr_q) & ~s.lk_clr;
    rd_evt = (s.rd2 ^ s.rd_q) & ~s.lk_clr;

    // address strap caught once after release of power-on reset
    if (!s.strap_done) begin
      if (s.strap_cnt == marl_pkg::STRAP_SETTLE) begin
        next_s.addr_lo    = s.as2;
        next_s.strap_done = 1'b1;
      end else begin
        next_s.strap_cnt = s.strap_cnt + 2'h1;
      end
    end

    // limit comparison and pin functions
    next_s.val = TEMPS;
    digital = ~s.cfg[marl_pkg::CFG_DIODE2_MODE];
    gpi_act = digital & (s.gp2 == s.cfg[marl_pkg::CFG_GPI_POLARITY]);
    hw_trip = ($signed(s.val.internal) >= $signed(HW_TRIP)) |
              ($signed(s.val.remote1) >= $signed(HW_TRIP)) |
              (~digital & ($signed(s.val.remote2) >= $signed(HW_TRIP)));
    // own drive is seen two cycles late through the synchroniser
    ext_therm = digital & ~s.th2 & ~s.therm_oe & ~|s.th_hist;
    ext_sup   = ~s.srp2 & ~s.sup_oe & ~|s.sup_hist;
    set = 8'h00;
    set[marl_pkg::ST_INTERNAL] =
      $signed(s.val.internal) > $signed(s.lim_int);
    set[marl_pkg::ST_REMOTE1] = $signed(s.val.remote1) > $signed(s.lim_r1);
    set[marl_pkg::ST_REMOTE2] =
      ~digital & ($signed(s.val.remote2) > $signed(s.lim_r2));
    set[marl_pkg::ST_OVERTEMP] = ext_therm;
    set[marl_pkg::ST_GPI]      = gpi_act;
    set[marl_pkg::ST_HW_TRIP]  = hw_trip;

    // status read clears; a new event in the same cycle still sets
    rd_hit = rd_evt & ((s.ptr == marl_pkg::REG_STATUS) |
                       (s.ptr == marl_pkg::REG_STATUS_MIRROR));
    clr = rd_hit ? 8'hff : 8'h00;
    if (gpi_act) begin
      clr[marl_pkg::ST_GPI] = 1'b0;
    end
    next_s.status = (s.status & ~clr) | set;

    // bus writes: first byte is the pointer, later bytes the register
    if (wr_evt) begin
      if (evt.first) begin
        next_s.ptr = evt.data;
      end else begin
        case (s.ptr)
          marl_pkg::REG_CONFIG:        next_s.cfg = evt.data;
          marl_pkg::REG_MASK:          next_s.mask = evt.data;
          marl_pkg::REG_ANALOG_OUT:    next_s.aout = evt.data;
          marl_pkg::REG_LIMIT_INT:     next_s.lim_int = evt.data;
          marl_pkg::REG_LIMIT_REMOTE1: next_s.lim_r1 = evt.data;
          marl_pkg::REG_LIMIT_REMOTE2: next_s.lim_r2 = evt.data;
          default:                     next_s.ptr = s.ptr;
        endcase
      end
    end

    // read data follows the pointer, ready before the link samples it
    case (s.ptr)
      marl_pkg::REG_CONFIG:        next_s.rd_byte = s.cfg;
      marl_pkg::REG_STATUS:        next_s.rd_byte = s.status;
      marl_pkg::REG_STATUS_MIRROR: next_s.rd_byte = s.status;
      marl_pkg::REG_MASK:          next_s.rd_byte = s.mask;
      marl_pkg::REG_ANALOG_OUT:    next_s.rd_byte = s.aout;
      marl_pkg::REG_LIMIT_INT:     next_s.rd_byte = s.lim_int;
      marl_pkg::REG_LIMIT_REMOTE1: next_s.rd_byte = s.lim_r1;
      marl_pkg::REG_LIMIT_REMOTE2: next_s.rd_byte = s.lim_r2;
      marl_pkg::REG_TEMP_INTERNAL: next_s.rd_byte = s.val.internal;
      marl_pkg::REG_TEMP_REMOTE1:  next_s.rd_byte = s.val.remote1;
      marl_pkg::REG_TEMP_REMOTE2:  next_s.rd_byte = s.val.remote2;
      default:                     next_s.rd_byte = 8'h00;
    endcase

    // external pull on the supply reset pin restores register defaults
    if (ext_sup) begin
      next_s.cfg     = marl_pkg::CONFIG_RESET;
      next_s.mask    = marl_pkg::MASK_RESET;
      next_s.aout    = marl_pkg::ANALOG_OUT_RESET;
      next_s.lim_int = marl_pkg::LIMIT_RESET;
      next_s.lim_r1  = marl_pkg::LIMIT_RESET;
      next_s.lim_r2  = marl_pkg::LIMIT_RESET;
      next_s.status  = 8'h00;
      next_s.ptr     = 8'h00;
    end

    // reset generators; any reassertion restarts the hold count
    if (s.sup2) begin
      next_s.sup_cnt = '0;
      next_s.sup_oe  = 1'b1;
    end else if (s.sup_cnt != HOLD) begin
      next_s.sup_cnt = s.sup_cnt + HW'(1);
      next_s.sup_oe  = 1'b1;
    end else begin
      next_s.sup_oe = 1'b0;
    end
    sys_cond = s.sup2 | s.aux2 | ~s.mr2 | ~s.srp2;
    if (sys_cond) begin
      next_s.sys_cnt = '0;
      next_s.sys_oe  = 1'b1;
    end else if (s.sys_cnt != HOLD) begin
      next_s.sys_cnt = s.sys_cnt + HW'(1);
      next_s.sys_oe  = 1'b1;
    end else begin
      next_s.sys_oe = 1'b0;
    end
    next_s.sup_hist = {s.sup_hist[0], s.sup_oe};
    next_s.th_hist  = {s.th_hist[0], s.therm_oe};

    // alert and overtemperature outputs, fan code, test mode
    next_s.therm_oe = digital & |set[marl_pkg::ST_REMOTE1:0] |
                      (digital & hw_trip);
    next_s.alert_oe = s.cfg[marl_pkg::CFG_INT_ENABLE] &
                      |(s.status & ~s.mask);
    next_s.fan_code = (hw_trip | ext_therm) ?
                      marl_pkg::FAN_FULL : s.aout;
    next_s.test_oe  = s.tst2;
    next_s.test_out = ~&{s.mr2, s.gp2, s.th2, s.srp2};
  end

  // state register; resets hold all reset pins asserted
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s         <= '0;
      s.lk_idle <= 1'b1;
      s.lk_clr  <= 1'b1;
      s.sup_oe  <= 1'b1;
      s.sys_oe  <= 1'b1;
      // idle pin levels, so no false overtemp or input event after reset
      s.th1     <= 1'b1;
      s.th2     <= 1'b1;
      s.gp1     <= 1'b1;
      s.gp2     <= 1'b1;
      s.cfg     <= marl_pkg::CONFIG_RESET;
      s.mask    <= marl_pkg::MASK_RESET;
      s.aout    <= marl_pkg::ANALOG_OUT_RESET;
      s.lim_int <= marl_pkg::LIMIT_RESET;
      s.lim_r1  <= marl_pkg::LIMIT_RESET;
      s.lim_r2  <= marl_pkg::LIMIT_RESET;
    end else begin
      s <= next_s;
    end
  end

  // open-drain pins expose only pull-low enables
  assign SDA_OE                        = link_sda_oe;
  assign SUPPLY_RESET_N_OE             = s.sup_oe;
  assign SYSTEM_RESET_N_OE             = s.sys_oe;
  assign FAN_OFF_OE                    = s.cfg[marl_pkg::CFG_FAN_OFF];
  assign FAN_SPEED_ENABLE              = ~s.test_oe;
  assign FAN_SPEED_CODE                = s.fan_code;
  assign DIODE2_ANALOG_MODE            = s.cfg[marl_pkg::CFG_DIODE2_MODE];
  assign DIODE2_NEG_OR_OVERTEMP_N_OE   = s.therm_oe;
  assign ADDRESS_SELECT_OR_TEST_OUT    = s.test_out;
  assign ADDRESS_SELECT_OR_TEST_OUT_OE = s.test_oe;
  assign ALERT_OE                      = s.alert_oe;

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_manual_holds: assert property (!s.mr2 |=> SYSTEM_RESET_N_OE)
    else $error("system reset not held during manual reset");
  a_sys_release: assert property (
    $fell(SYSTEM_RESET_N_OE) |-> s.sys_cnt == HOLD && !$past(sys_cond))
    else $error("system reset released before hold period");
  a_sup_holds: assert property (
    s.sup2 |=> SUPPLY_RESET_N_OE && s.sup_cnt == '0)
    else $error("supply reset not asserted while supply low");
  a_sup_release: assert property (
    $fell(SUPPLY_RESET_N_OE) |-> s.sup_cnt == HOLD)
    else $error("supply reset released early");
  a_hold_restart: assert property (
    (s.aux2 && !s.sup2) |=> s.sys_cnt == '0 ##1
      s.sys_cnt == HW'(1) || $past(s.aux2))
    else $error("hold count not restarted");
  a_alert_gate: assert property (
    ALERT_OE |-> $past(s.cfg[marl_pkg::CFG_INT_ENABLE]) &&
                 $past(|(s.status & ~s.mask)))
    else $error("alert without enabled unmasked source");
  a_fan_full: assert property ((hw_trip || ext_therm)
    |=> FAN_SPEED_CODE == marl_pkg::FAN_FULL)
    else $error("fan not forced full on trip");
  a_gpi_sticky: assert property (
    (s.status[marl_pkg::ST_GPI] && !ext_sup && !(rd_hit && !gpi_act)) |=>
      s.status[marl_pkg::ST_GPI])
    else $error("general input status lost without read");
  a_therm_drive: assert property (
    (digital && set[marl_pkg::ST_INTERNAL]) |=> DIODE2_NEG_OR_OVERTEMP_N_OE)
    else $error("overtemp pin not driven on violation");
  a_strap_fixed: assert property (
    s.strap_done |=> $stable(s.addr_lo))
    else $error("address strap changed after capture");
  a_test_pin: assert property (
    ADDRESS_SELECT_OR_TEST_OUT_OE == $past(s.tst2))
    else $error("address pin drive not following test mode");

  c_write_ptr: cover property (wr_evt && evt.first);
  c_status_read: cover property (rd_hit ##1 s.status == 8'h00);
  c_sys_release: cover property ($fell(SYSTEM_RESET_N_OE));
  c_ext_therm: cover property (ext_therm);

endmodule : marl_core

// file: marl_host.sv
/*
  bus host model: master timing on the clock and data pins.
  assumes the data pin is resolved with a pull-up outside.
*/
`timescale 1ns/1ps
module marl_host (
  // bus pins
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // idle bus: clock high, data released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // data moves only in the low phase, well clear of the fall
  task automatic slot(input logic b, output logic s);
    #300 sda_low = ~b;
    #1200 scl = 1'b1;
    #700 s = sda;
    #800 scl = 1'b0;
  endtask : slot
  // msb first; the ninth slot is always released, so reads end nacked
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic n);
    for (int i = 7; i >= 0; i--) begin
      slot(d[i], q[i]);
    end
    slot(1'b1, n);
  endtask : xfer
  // start, or repeated start when the clock is low
  task automatic start();
    #300 sda_low = 1'b0;
    #400 scl = 1'b1;
    #700 sda_low = 1'b1;
    #1500 scl = 1'b0;
  endtask : start
  // stop, then bus free time
  task automatic stop();
    #300 sda_low = 1'b1;
    #1200 scl = 1'b1;
    #700 sda_low = 1'b0;
    #1500;
  endtask : stop
  // pointer byte first, then a data byte or a repeated-start read
  task automatic op(input logic [6:0] a, input logic [7:0] p, d,
                    input logic rd, output logic [7:0] q,
                    output logic ok);
    logic [7:0] x;
    logic       n;
    start();
    xfer({a, 1'b0}, x, n);
    ok = ~n;
    xfer(p, x, n);
    if (rd) begin
      start();
      xfer({a, 1'b1}, x, n);
      xfer(8'hff, q, n);
    end else begin
      xfer(d, x, n);
    end
    stop();
  endtask : op
endmodule : marl_host

// file: marl_core_tb.sv
/*
  bench for marl_core: reset sources, register traffic, pins.
  assumes marl_host drives the bus; pins are resolved here.
*/
`timescale 1ns/1ps
module marl_core_tb;
  logic CLOCK = 1'b0, RST = 1'b1, SCL, SDA_IN, SDA_OE, sda_low;
  logic SUPPLY_BELOW, AUX_VOLTAGE_MONITOR, MANUAL_RESET_N;
  logic FAN_SPEED_OUT_OR_TEST_IN = 1'b0, brd = 1'b0, ext = 1'b0;
  logic DIODE2_POS_OR_GENERAL_INPUT = 1'b1;
  logic [1:0] ADDRESS_SELECT = 2'h0;
  logic [2:0] lv = 3'h1;
  marl_pkg::marl_temps_t TEMPS = '0;
  logic SUPPLY_RESET_N_IN, SUPPLY_RESET_N_OE, SYSTEM_RESET_N_OE;
  logic FAN_OFF_OE, FAN_SPEED_ENABLE, DIODE2_ANALOG_MODE, ALERT_OE;
  logic DIODE2_NEG_OR_OVERTEMP_N_IN, DIODE2_NEG_OR_OVERTEMP_N_OE;
  logic ADDRESS_SELECT_OR_TEST_OUT, ADDRESS_SELECT_OR_TEST_OUT_OE, ok;
  logic [7:0] FAN_SPEED_CODE, q;
  logic [2:0] src [3] = '{3'h0, 3'h3, 3'h5};
  logic [7:0] ofs [4] = '{8'h40, 8'h43, 8'h19, 8'h39};
  logic [7:0] rv  [4] = '{8'h00, 8'h00, 8'hff, 8'h7f};
  int fail_count = 0, checks = 0;
  // open-drain pins read low when any party pulls
  assign SDA_IN = ~(SDA_OE | sda_low);
  assign SUPPLY_RESET_N_IN = ~(SUPPLY_RESET_N_OE | brd);
  assign DIODE2_NEG_OR_OVERTEMP_N_IN = ~(DIODE2_NEG_OR_OVERTEMP_N_OE | ext);
  assign {SUPPLY_BELOW, AUX_VOLTAGE_MONITOR, MANUAL_RESET_N} = lv;
  marl_core #(.RESET_HOLD_CYCLES(20)) dut (.*);
  marl_host host (.scl(SCL), .sda_low(sda_low), .sda(SDA_IN));
  // 20 MHz monitor clock
  always #25 CLOCK = ~CLOCK;
  task automatic chk(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge CLOCK);
  endtask : cyc
  task automatic wr(input logic [7:0] p, d);
    host.op(7'h2c, p, d, 1'b0, q, ok);
    cyc(10);
  endtask : wr
  task automatic rd(input logic [7:0] p, e);
    host.op(7'h2c, p, 8'h00, 1'b1, q, ok);
    chk(q, e);
    cyc(2);
  endtask : rd
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // hang guard, a little under twice the normal run length
  initial begin
    #4_000_000;
    fail_count++;
    final_report();
  end
  // main sequence
  initial begin
    cyc(20);
    RST = 1'b0;
    cyc(10);
    chk(SUPPLY_RESET_N_OE, 8'h1);
    cyc(40);
    chk(SYSTEM_RESET_N_OE, 8'h0);
    chk(FAN_SPEED_ENABLE, 8'h1);
    // a short reassert inside the hold must restart it
    for (int k = 0; k < 3; k++) begin
      lv = src[k];
      cyc(30);
      chk(SYSTEM_RESET_N_OE, 8'h1);
      chk(SUPPLY_RESET_N_OE, 8'(k == 2));
      lv = 3'h1;
      cyc(12);
      chk(SYSTEM_RESET_N_OE, 8'h1);
      lv = src[k];
      cyc(5);
      lv = 3'h1;
      cyc(15);
      chk(SYSTEM_RESET_N_OE, 8'h1);
      cyc(50);
      chk(SYSTEM_RESET_N_OE, 8'h0);
    end
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i], rv[i]);
    end
    rd(8'h7e, 8'h00);
    // strap moved after power-up: old address only
    ADDRESS_SELECT = 2'h3;
    host.op(7'h2f, 8'h40, 8'h00, 1'b0, q, ok);
    chk(ok, 8'h0);
    wr(8'h40, 8'h86);
    chk(DIODE2_ANALOG_MODE, 8'h1);
    chk(FAN_OFF_OE, 8'h1);
    rd(8'h40, 8'h86);
    wr(8'h40, 8'h00);
    wr(8'h39, 8'h20);
    TEMPS.internal = 8'h30;
    cyc(8);
    chk(ALERT_OE, 8'h0);
    chk(DIODE2_NEG_OR_OVERTEMP_N_OE, 8'h1);
    wr(8'h40, 8'h02);
    chk(ALERT_OE, 8'h1);
    wr(8'h43, 8'h01);
    chk(ALERT_OE, 8'h0);
    TEMPS.internal = 8'h00;
    rd(8'h4c, 8'h01);
    wr(8'h19, 8'h40);
    chk(FAN_SPEED_CODE, 8'h40);
    ext = 1'b1;
    cyc(8);
    chk(FAN_SPEED_CODE, 8'hff);
    ext = 1'b0;
    rd(8'h41, 8'h08);
    TEMPS.internal = 8'h50;
    cyc(8);
    chk(FAN_SPEED_CODE, 8'hff);
    TEMPS.internal = 8'h00;
    rd(8'h41, 8'h21);
    // input latch survives reads while active
    wr(8'h40, 8'h08);
    rd(8'h41, 8'h10);
    DIODE2_POS_OR_GENERAL_INPUT = 1'b0;
    rd(8'h41, 8'h10);
    rd(8'h41, 8'h00);
    FAN_SPEED_OUT_OR_TEST_IN = 1'b1;
    cyc(5);
    chk(FAN_SPEED_ENABLE, 8'h0);
    chk(ADDRESS_SELECT_OR_TEST_OUT_OE, 8'h1);
    chk(ADDRESS_SELECT_OR_TEST_OUT, 8'h1);
    FAN_SPEED_OUT_OR_TEST_IN = 1'b0;
    // board pulls the supply reset pin itself
    wr(8'h40, 8'h04);
    brd = 1'b1;
    cyc(10);
    chk(SYSTEM_RESET_N_OE, 8'h1);
    chk(FAN_OFF_OE, 8'h0);
    brd = 1'b0;
    cyc(80);
    chk(SYSTEM_RESET_N_OE, 8'h0);
    final_report();
  end
endmodule : marl_core_tb
